// *** rtl/cpod_pkg.sv ***
`default_nettype none
package cpod_pkg;
  // register map, byte addresses on the 32-bit bus
  localparam logic [7:0] REG_OPCODE = 8'h00;
  localparam logic [7:0] REG_DECODE = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_EXEC = 8'h0c;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [4:0] CCR_RESET = 5'h08;
  // condition code bit positions
  localparam int CC_H = 4;
  localparam int CC_I = 3;
  localparam int CC_N = 2;
  localparam int CC_Z = 1;
  localparam int CC_C = 0;
  // high nibble columns of the opcode map
  localparam logic [3:0] HI_BITBR = 4'h0;
  localparam logic [3:0] HI_BITSC = 4'h1;
  localparam logic [3:0] HI_REL = 4'h2;
  localparam logic [3:0] HI_RMW_DIR = 4'h3;
  localparam logic [3:0] HI_RMW_ACC = 4'h4;
  localparam logic [3:0] HI_RMW_IDX = 4'h5;
  localparam logic [3:0] HI_RMW_IX1 = 4'h6;
  localparam logic [3:0] HI_RMW_IX0 = 4'h7;
  localparam logic [3:0] HI_CTL_A = 4'h8;
  localparam logic [3:0] HI_CTL_B = 4'h9;
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX2 = 4'hd;
  localparam logic [3:0] HI_IX1 = 4'he;
  localparam logic [3:0] HI_IX0 = 4'hf;
  // register/memory low nibbles
  localparam logic [3:0] LO_SUB = 4'h0;
  localparam logic [3:0] LO_CMP = 4'h1;
  localparam logic [3:0] LO_SBC = 4'h2;
  localparam logic [3:0] LO_CPX = 4'h3;
  localparam logic [3:0] LO_AND = 4'h4;
  localparam logic [3:0] LO_BIT = 4'h5;
  localparam logic [3:0] LO_LDA = 4'h6;
  localparam logic [3:0] LO_STORE_ACC = 4'h7;
  localparam logic [3:0] LO_EOR = 4'h8;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ORA = 4'ha;
  localparam logic [3:0] LO_ADD = 4'hb;
  localparam logic [3:0] LO_UNCOND_JUMP = 4'hc;
  localparam logic [3:0] LO_JUMP_SUB = 4'hd;
  localparam logic [3:0] LO_LDX = 4'he;
  localparam logic [3:0] LO_STORE_IDX = 4'hf;
  // read-modify-write low nibbles; mask marks the defined ones
  localparam logic [3:0] LO_NEG = 4'h0;
  localparam logic [3:0] LO_COM = 4'h3;
  localparam logic [3:0] LO_LSR = 4'h4;
  localparam logic [3:0] LO_ROR = 4'h6;
  localparam logic [3:0] LO_ASR = 4'h7;
  localparam logic [3:0] LO_LSL = 4'h8;
  localparam logic [3:0] LO_ROL = 4'h9;
  localparam logic [3:0] LO_DEC = 4'ha;
  localparam logic [3:0] LO_INC = 4'hc;
  localparam logic [3:0] LO_TST = 4'hd;
  localparam logic [3:0] LO_CLR = 4'hf;
  localparam logic [15:0] RMW_DEF_MASK = 16'hb7d9;
  // control opcodes
  localparam logic [7:0] OPC_RETURN_FROM_INTERRUPT = 8'h80;
  localparam logic [7:0] OPC_RETURN_FROM_SUB = 8'h81;
  localparam logic [7:0] OPC_SOFTWARE_INTERRUPT = 8'h83;
  localparam logic [7:0] OPC_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'h98;
  localparam logic [7:0] OPC_SET_CARRY = 8'h99;
  localparam logic [7:0] OPC_CLEAR_MASK = 8'h9a;
  localparam logic [7:0] OPC_SET_MASK = 8'h9b;
  localparam logic [7:0] OPC_STACK_POINTER_RESET = 8'h9c;
  localparam logic [7:0] OPC_NO_OPERATION = 8'h9d;
  localparam logic [7:0] OPC_INDEX_TO_ACC = 8'h9f;
  localparam logic [7:0] OPC_BRANCH_TO_SUB = 8'had;
  // lengths and cycle counts
  localparam logic [1:0] LEN1 = 2'd1;
  localparam logic [1:0] LEN2 = 2'd2;
  localparam logic [1:0] LEN3 = 2'd3;
  localparam logic [3:0] CYC_BITBR = 4'd10;
  localparam logic [3:0] CYC_BITSC = 4'd7;
  localparam logic [3:0] CYC_REL = 4'd4;
  localparam logic [3:0] CYC_RMW_DIR = 4'd6;
  localparam logic [3:0] CYC_RMW_REG = 4'd4;
  localparam logic [3:0] CYC_RMW_IX1 = 4'd7;
  localparam logic [3:0] CYC_RMW_IX0 = 4'd6;
  localparam logic [3:0] CYC_IMPLIED = 4'd2;
  localparam logic [3:0] CYC_RET_INT = 4'd9;
  localparam logic [3:0] CYC_RET_SUB = 4'd6;
  localparam logic [3:0] CYC_SOFT_INT = 4'd11;
  localparam logic [3:0] CYC_BRANCH_SUB = 4'd8;
  localparam logic [3:0] CYC_IMM = 4'd2;
  localparam logic [3:0] CYC_DIR = 4'd4;
  localparam logic [3:0] CYC_EXT = 4'd5;
  localparam logic [3:0] CYC_IX2 = 4'd6;
  localparam logic [3:0] CYC_IX1 = 4'd5;
  localparam logic [3:0] CYC_IX0 = 4'd4;
  localparam logic [3:0] CYC_STORE_ADJ = 4'd1;
  localparam logic [3:0] CYC_JUMP_ADJ = 4'd1;
  localparam logic [3:0] CYC_JSUB_ADJ = 4'd3;

  typedef enum logic [2:0] {
    kind_none = 3'b000, kind_bitbr = 3'b001, kind_bitsc = 3'b010, kind_rel = 3'b011,
    kind_rmw = 3'b100, kind_regmem = 3'b101, kind_ctrl = 3'b110
  } cpod_kind_t;
  typedef enum logic [3:0] {
    mode_none = 4'h0, mode_inh = 4'h1, mode_imm = 4'h2, mode_dir = 4'h3, mode_ext = 4'h4,
    mode_ix2 = 4'h5, mode_ix1 = 4'h6, mode_ix0 = 4'h7, mode_rel = 4'h8, mode_acc = 4'h9,
    mode_idx = 4'ha
  } cpod_mode_t;
  typedef struct packed {
    logic valid;
    cpod_kind_t kind;
    cpod_mode_t mode;
    logic [3:0] op;
    logic [1:0] len;
    logic [3:0] cyc;
    logic [2:0] bitn;
    logic set_form;
  } cpod_dec_t;
endpackage
`default_nettype wire

// *** rtl/cpod_top.sv ***
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module cpod_top import cpod_pkg::*; (
  input wire logic aclk, // core clock, 250 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address taken
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data taken
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response accepted
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address taken
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data accepted
);

  // opcode decoder, shared by the fetch path and the register view
  function automatic cpod_dec_t cpod_decode(input logic [7:0] opc);
    cpod_dec_t d;
    logic [3:0] hi;
    logic [3:0] lo;
    d = '0;
    hi = opc[7:4];
    lo = opc[3:0];
    d.op = lo;
    d.bitn = lo[3:1];
    d.set_form = ~lo[0];
    unique case (hi)
      HI_BITBR: begin
        d.valid = 1'b1;
        d.kind = kind_bitbr;
        d.mode = mode_dir;
        d.len = LEN3;
        d.cyc = CYC_BITBR;
      end
      HI_BITSC: begin
        d.valid = 1'b1;
        d.kind = kind_bitsc;
        d.mode = mode_dir;
        d.len = LEN2;
        d.cyc = CYC_BITSC;
      end
      HI_REL: begin
        d.valid = 1'b1;
        d.kind = kind_rel;
        d.mode = mode_rel;
        d.len = LEN2;
        d.cyc = CYC_REL;
      end
      HI_RMW_DIR, HI_RMW_ACC, HI_RMW_IDX, HI_RMW_IX1, HI_RMW_IX0: begin
        d.valid = RMW_DEF_MASK[lo];
        d.kind = kind_rmw;
        unique case (hi)
          HI_RMW_DIR: {d.mode, d.len, d.cyc} = {mode_dir, LEN2, CYC_RMW_DIR};
          HI_RMW_ACC: {d.mode, d.len, d.cyc} = {mode_acc, LEN1, CYC_RMW_REG};
          HI_RMW_IDX: {d.mode, d.len, d.cyc} = {mode_idx, LEN1, CYC_RMW_REG};
          HI_RMW_IX1: {d.mode, d.len, d.cyc} = {mode_ix1, LEN2, CYC_RMW_IX1};
          default: {d.mode, d.len, d.cyc} = {mode_ix0, LEN1, CYC_RMW_IX0};
        endcase
      end
      HI_CTL_A, HI_CTL_B: begin
        d.kind = kind_ctrl;
        d.mode = mode_inh;
        d.len = LEN1;
        d.valid = 1'b1;
        unique case (opc)
          OPC_RETURN_FROM_INTERRUPT: d.cyc = CYC_RET_INT;
          OPC_RETURN_FROM_SUB: d.cyc = CYC_RET_SUB;
          OPC_SOFTWARE_INTERRUPT: d.cyc = CYC_SOFT_INT;
          OPC_ACC_TO_INDEX, OPC_CLEAR_CARRY, OPC_SET_CARRY, OPC_CLEAR_MASK, OPC_SET_MASK,
          OPC_STACK_POINTER_RESET, OPC_NO_OPERATION, OPC_INDEX_TO_ACC: d.cyc = CYC_IMPLIED;
          default: d.valid = 1'b0;
        endcase
      end
      HI_IMM, HI_DIR, HI_EXT, HI_IX2, HI_IX1, HI_IX0: begin
        d.valid = 1'b1;
        d.kind = kind_regmem;
        unique case (hi)
          HI_IMM: {d.mode, d.len, d.cyc} = {mode_imm, LEN2, CYC_IMM};
          HI_DIR: {d.mode, d.len, d.cyc} = {mode_dir, LEN2, CYC_DIR};
          HI_EXT: {d.mode, d.len, d.cyc} = {mode_ext, LEN3, CYC_EXT};
          HI_IX2: {d.mode, d.len, d.cyc} = {mode_ix2, LEN3, CYC_IX2};
          HI_IX1: {d.mode, d.len, d.cyc} = {mode_ix1, LEN2, CYC_IX1};
          default: {d.mode, d.len, d.cyc} = {mode_ix0, LEN1, CYC_IX0};
        endcase
        // column counts adjusted per instruction
        if (lo == LO_STORE_ACC || lo == LO_STORE_IDX) d.cyc = d.cyc + CYC_STORE_ADJ;
        if (lo == LO_UNCOND_JUMP) d.cyc = d.cyc - CYC_JUMP_ADJ;
        if (lo == LO_JUMP_SUB) d.cyc = d.cyc + CYC_JSUB_ADJ;
        if (opc == OPC_BRANCH_TO_SUB) begin
          {d.kind, d.mode, d.len, d.cyc} = {kind_ctrl, mode_rel, LEN2, CYC_BRANCH_SUB};
        end else if (hi == HI_IMM && (lo == LO_STORE_ACC || lo == LO_STORE_IDX ||
                                       lo == LO_UNCOND_JUMP)) begin
          d.valid = 1'b0;
        end
      end
    endcase
    if (!d.valid) d = '0;
    return d;
  endfunction

  logic [7:0] opcode_q;
  cpod_dec_t dec_q;
  logic [12:0] pc_q;
  logic [4:0] ccr_q, ccr_d;
  logic [7:0] result_q, result_d;
  logic taken_q, taken_d;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rdata_d;

  // write channel: address and data taken together while no response is pending
  wire wr_fire = awvalid && wvalid && !bvalid_q;
  wire rd_fire = arvalid && !rvalid_q;
  wire wr_opc = wr_fire && awaddr == REG_OPCODE && wstrb[0];
  wire wr_pc = wr_fire && awaddr == REG_PC;
  wire wr_exec = wr_fire && awaddr == REG_EXEC && wstrb[1] && wstrb[0];
  wire wr_flags = wr_fire && awaddr == REG_FLAGS && wstrb[0];
  wire wr_mapped = awaddr == REG_OPCODE || awaddr == REG_PC || awaddr == REG_EXEC ||
                   awaddr == REG_FLAGS;
  wire rd_mapped = araddr == REG_OPCODE || araddr == REG_DECODE || araddr == REG_PC ||
                   araddr == REG_EXEC || araddr == REG_FLAGS;
  assign awready = wr_fire;
  assign wready = wr_fire;
  assign arready = rd_fire;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  // decode of the byte being fetched, and the program counter step it implies
  cpod_dec_t dec_w;
  assign dec_w = cpod_decode(wdata[7:0]);
  wire [12:0] pc_step = {11'h000, dec_w.len};
  wire [12:0] pc_wr = {wstrb[1] ? wdata[12:8] : pc_q[12:8], wstrb[0] ? wdata[7:0] : pc_q[7:0]};

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    rdata_d = '0;
    if (araddr == REG_OPCODE) rdata_d = {24'h000000, opcode_q};
    if (araddr == REG_DECODE) rdata_d = {10'h000, dec_q};
    if (araddr == REG_PC) rdata_d = {19'h00000, pc_q};
    if (araddr == REG_EXEC) rdata_d = {23'h000000, taken_q, result_q};
    if (araddr == REG_FLAGS) rdata_d = {27'h0000000, ccr_q};
  end

  // execution of the decoded instruction on the written operands:
  // wdata[7:0] is the register operand, wdata[15:8] the memory or stacked byte
  wire [7:0] op_reg = wdata[7:0];
  wire [7:0] op_mem = wdata[15:8];
  wire cin = ccr_q[CC_C];
  always_comb begin
    logic [8:0] sum;
    logic [4:0] hsum;
    logic upd_nz;
    logic addc;
    sum = '0;
    hsum = '0;
    upd_nz = 1'b0;
    addc = dec_q.op == LO_ADC && cin;
    ccr_d = ccr_q;
    result_d = op_reg;
    taken_d = 1'b0;
    unique case (dec_q.kind)
      kind_regmem: begin
        upd_nz = dec_q.op != LO_UNCOND_JUMP && dec_q.op != LO_JUMP_SUB;
        unique case (dec_q.op)
          LO_SUB, LO_CMP, LO_CPX, LO_SBC: begin
            sum = {1'b0, op_reg} - {1'b0, op_mem} - {8'h00, dec_q.op == LO_SBC && cin};
            result_d = sum[7:0];
            ccr_d[CC_C] = sum[8];
          end
          LO_ADD, LO_ADC: begin
            sum = {1'b0, op_reg} + {1'b0, op_mem} + {8'h00, addc};
            hsum = {1'b0, op_reg[3:0]} + {1'b0, op_mem[3:0]} + {4'h0, addc};
            result_d = sum[7:0];
            ccr_d[CC_C] = sum[8];
            ccr_d[CC_H] = hsum[4];
          end
          LO_AND, LO_BIT: result_d = op_reg & op_mem;
          LO_EOR: result_d = op_reg ^ op_mem;
          LO_ORA: result_d = op_reg | op_mem;
          LO_LDA, LO_LDX: result_d = op_mem;
          LO_STORE_ACC, LO_STORE_IDX, LO_UNCOND_JUMP, LO_JUMP_SUB: result_d = op_reg;
        endcase
      end
      kind_rmw: begin
        upd_nz = 1'b1;
        result_d = op_mem;
        unique case (dec_q.op)
          LO_NEG: begin
            result_d = 8'h00 - op_mem;
            ccr_d[CC_C] = op_mem != 8'h00;
          end
          LO_COM: {ccr_d[CC_C], result_d} = {1'b1, ~op_mem};
          LO_LSR: {result_d, ccr_d[CC_C]} = {1'b0, op_mem};
          LO_ROR: {result_d, ccr_d[CC_C]} = {cin, op_mem};
          LO_ASR: {result_d, ccr_d[CC_C]} = {op_mem[7], op_mem};
          LO_LSL: {ccr_d[CC_C], result_d} = {op_mem, 1'b0};
          LO_ROL: {ccr_d[CC_C], result_d} = {op_mem, cin};
          LO_DEC: result_d = op_mem - 8'h01;
          LO_INC: result_d = op_mem + 8'h01;
          LO_CLR: result_d = 8'h00;
          default: result_d = op_mem; // test only
        endcase
      end
      kind_bitbr: begin
        ccr_d[CC_C] = op_mem[dec_q.bitn];
        taken_d = op_mem[dec_q.bitn] == dec_q.set_form;
        result_d = op_mem;
      end
      kind_bitsc: begin
        result_d = op_mem;
        result_d[dec_q.bitn] = dec_q.set_form;
      end
      kind_ctrl: begin
        unique case (opcode_q)
          OPC_RETURN_FROM_INTERRUPT: ccr_d = op_mem[4:0];
          OPC_CLEAR_CARRY: ccr_d[CC_C] = 1'b0;
          OPC_SET_CARRY: ccr_d[CC_C] = 1'b1;
          OPC_CLEAR_MASK: ccr_d[CC_I] = 1'b0;
          OPC_SET_MASK, OPC_SOFTWARE_INTERRUPT: ccr_d[CC_I] = 1'b1;
          default: ccr_d = ccr_q;
        endcase
      end
      kind_rel, kind_none: result_d = op_reg;
      default: result_d = op_reg;
    endcase
    if (upd_nz) begin
      ccr_d[CC_N] = result_d[7];
      ccr_d[CC_Z] = result_d == 8'h00;
    end
  end

  // architectural state: opcode, decode, program counter, flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opcode_q <= 8'h00;
      dec_q <= '0;
      pc_q <= PC_RESET;
      ccr_q <= CCR_RESET;
      result_q <= 8'h00;
      taken_q <= 1'b0;
    end else begin
      if (wr_opc) opcode_q <= wdata[7:0];
      if (wr_opc) dec_q <= dec_w;
      if (wr_opc) pc_q <= pc_q + pc_step;
      else if (wr_pc) pc_q <= pc_wr;
      if (wr_exec) ccr_q <= ccr_d;
      else if (wr_flags) ccr_q <= wdata[4:0];
      if (wr_exec) result_q <= result_d;
      if (wr_exec) taken_q <= taken_d;
    end
  end

  // bus responses stand until the master accepts them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      if (wr_fire) bvalid_q <= 1'b1;
      else if (bready) bvalid_q <= 1'b0;
      if (wr_fire) bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      if (rd_fire) rvalid_q <= 1'b1;
      else if (rready) rvalid_q <= 1'b0;
      if (rd_fire) rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      if (rd_fire) rdata_q <= rdata_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [3:0] opc_hi = opcode_q[7:4];
  wire [4:0] chk_h = {1'b0, op_reg[3:0]} + {1'b0, op_mem[3:0]};
  wire [1:0] new_len = dec_w.len;

  a_undef_empty: assert property (wr_opc && wdata[7:0] == 8'h82 |=> !dec_q.valid && dec_q.len == 2'd0
    && pc_q == $past(pc_q)) else $error("undefined opcode decoded");
  a_bit_timing: assert property ((dec_q.kind == kind_bitbr |-> dec_q.len == 2'd3
    && dec_q.cyc == 4'd10) and (dec_q.kind == kind_bitsc |-> dec_q.len == 2'd2 && dec_q.cyc == 4'd7))
    else $error("bit instruction timing wrong");
  a_rmw_timing: assert property (dec_q.kind == kind_rmw |-> (opc_hi == 4'h3 && dec_q.cyc == 4'd6)
    || (opc_hi == 4'h4 && dec_q.cyc == 4'd4) || (opc_hi == 4'h5 && dec_q.len == 2'd1)
    || (opc_hi == 4'h6 && dec_q.cyc == 4'd7) || (opc_hi == 4'h7 && dec_q.cyc == 4'd6))
    else $error("read-modify-write timing wrong");
  a_column_timing: assert property (dec_q.valid && opc_hi == 4'hc && opcode_q[3:0] == 4'h6
    |-> dec_q.len == 2'd3 && dec_q.cyc == 4'd5) else $error("extended load timing wrong");
  a_special_cycles: assert property (opcode_q == 8'h83 |-> dec_q.cyc == 4'd11)
    else $error("software interrupt cycles wrong");
  a_col_adjust: assert property ((opcode_q == 8'hdd |-> dec_q.cyc == 4'd9)
    and (opcode_q == 8'hb7 |-> dec_q.cyc == 4'd5) and (opcode_q == 8'hfc |-> dec_q.cyc == 4'd3))
    else $error("column adjustment wrong");
  a_bit_fields: assert property (opc_hi == 4'h1 |-> dec_q.bitn == opcode_q[3:1]
    && dec_q.set_form == !opcode_q[0]) else $error("bit number or form wrong");
  a_rel_decode: assert property (opc_hi == 4'h2 |-> dec_q.kind == kind_rel
    && dec_q.op == opcode_q[3:0] && dec_q.cyc == 4'd4) else $error("relative branch decode wrong");
  a_regmem_mode: assert property (opcode_q == 8'he0 |-> dec_q.kind == kind_regmem
    && dec_q.mode == mode_ix1 && dec_q.len == 2'd2) else $error("register/memory mode wrong");
  a_rmw_gaps: assert property (opc_hi == 4'h5 && opcode_q[3:0] == 4'h1 |-> !dec_q.valid)
    else $error("undefined read-modify-write decoded");
  a_control_set: assert property (opcode_q == 8'h9c |-> dec_q.valid && dec_q.kind == kind_ctrl)
    else $error("stack pointer reset not decoded");
  a_pc_advance: assert property (wr_opc |=> pc_q == $past(pc_q) + {11'h000, $past(new_len)})
    else $error("program counter step wrong");
  a_half_carry: assert property (wr_exec && dec_q.kind == kind_regmem && dec_q.op == LO_ADD
    |=> ccr_q[CC_H] == $past(chk_h[4])) else $error("half carry wrong");
  a_zero_flag: assert property (wr_exec && dec_q.kind == kind_regmem && dec_q.op == LO_LDA
    && op_mem == 8'h00 |=> ccr_q[CC_Z] && !ccr_q[CC_N]) else $error("zero flag wrong");
  a_flag_reload: assert property (wr_exec && opcode_q == 8'h80 && dec_q.valid
    |=> ccr_q == $past(wdata[12:8])) else $error("flag reload wrong");
  a_flag_keep: assert property (wr_exec && opcode_q == 8'h9d && dec_q.valid |=> $stable(ccr_q))
    else $error("flags changed on no operation");
  a_page0_mode: assert property (dec_q.kind inside {kind_bitbr, kind_bitsc} |-> dec_q.mode == mode_dir)
    else $error("bit instruction not direct");
  c_fetch_exec: cover property (wr_opc ##[1:20] wr_exec);
  c_branch_taken: cover property (wr_exec && dec_q.kind == kind_bitbr ##1 taken_q);
  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// *** verif/cpod_prog_mem.sv ***
`default_nettype none
module cpod_prog_mem (
  input wire logic [4:0] addr, // byte slot in the test program
  output logic [7:0] opcode // opcode stored in that slot
);
  timeunit 1ns;
  timeprecision 1ps;
  // opcodes at successive slots, read out in program order
  localparam logic [199:0] ROM =
    200'h0e132f3c4a5f6d709dabb6c0d9e4fe808183b7ccddad8241a7;
  assign opcode = ROM[8*(24-32'(addr)) +: 8];
endmodule
`default_nettype wire

// *** verif/cpod_top_bench.sv ***
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module cpod_top_bench;
  import cpod_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
  logic arvalid = 0, rready = 1, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0, op, ex;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, r;
  logic [12:0] pc;
  logic [4:0] ia = 0;
  int n_fail = 0, samples_checked = 0;
  // expected {length, cycles} per program slot, 00 for undefined
  localparam logic [199:0] EXP =
    200'h3a272426141427161222243536251419161b25343928000000;
  cpod_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  cpod_prog_mem rom (.addr(ia), .opcode(op));
  initial forever #2 aclk = ~aclk;
  // bready and rready stay high, so the answer is taken on its first cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1; wvalid <= 1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 0; wvalid <= 0;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata; r = rresp;
  endtask
  // decode an opcode, preset flags, execute, and compare the flags
  task automatic run(input logic [7:0] o, input logic [4:0] f, input logic [15:0] v,
      input logic [4:0] e);
    wr(REG_OPCODE, {24'h0, o}, 4'h1);
    wr(REG_FLAGS, {27'h0, f}, 4'h1);
    wr(REG_EXEC, {16'h0, v}, 4'h3);
    rd(REG_FLAGS);
    `CHK("flags", {27'h0, e}, d)
  endtask
  function automatic logic [2:0] kind_of(input logic [7:0] o);
    if (o == 8'had || o[7:4] == 4'h8 || o[7:4] == 4'h9) return 3'd6;
    if (o[7:4] >= 4'ha) return 3'd5;
    if (o[7:4] >= 4'h3) return 3'd4;
    return o[6:4] + 3'd1;
  endfunction
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hang costs a mismatch; the tests need well under 1500 cycles
  initial begin
    #40000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    pc = 13'h1ff8; // start near the top so the counter wraps
    wr(REG_PC, {19'h0, pc}, 4'hf);
    for (int i = 0; i < 25; i++) begin
      ex = EXP[8*(24-i) +: 8];
      wr(REG_OPCODE, {24'h0, op}, 4'h1);
      rd(REG_DECODE);
      `CHK("len cyc", ex, {d[9:8] + 4'h0, d[7:4]})
      if (ex == 8'h00) `CHK("undefined", 32'h0, d)
      else begin
        `CHK("kind", kind_of(op), d[20:18])
        if (op[7:5] == 3'h0) `CHK("bit", {op[3:1], ~op[0]}, d[3:0])
        if (kind_of(op) != 3'd6) `CHK("op", op[3:0], d[13:10])
      end
      pc = pc + 13'(ex[7:4]);
      ia = ia + 5'd1;
      rd(REG_PC);
      `CHK("pc", {19'h0, pc}, d)
    end
    run(8'hab, 5'h08, 16'h010f, 5'h18);
    rd(REG_EXEC);
    `CHK("sum", 8'h10, d[7:0])
    run(8'hab, 5'h08, 16'h8080, 5'h0b);
    run(8'h80, 5'h00, 16'h1500, 5'h15);
    run(8'h98, 5'h1f, 16'h0000, 5'h1e);
    rd(8'h14);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {r, d})
    wr(REG_DECODE, 32'h0, 4'hf);
    `CHK("decode write", RESP_SLVERR, r)
    stop_test();
  end
endmodule
`default_nettype wire
